// >>> logic/wac_capability.sv
/*
 write atomicity capability registers and the per-command atomicity verdict.
 assumes a classic wishbone master on ref_clk and a command source on the same clock.
*/
`timescale 1ns/1ps
module wac_capability (
    input  wire logic                  ref_clk,   // 250 MHz clock
    input  wire logic                  rst_b,     // synchronous reset, active low
    input  wire wac_pkg::wac_wb_req_t  wbReq,     // wishbone request
    output logic                       wbAck,     // wishbone acknowledge
    output logic [31:0]                wbDatOut,  // wishbone read data
    input  wire wac_pkg::wac_cmd_t     cmd,       // command classification request
    output wac_pkg::wac_verdict_t      verdict    // registered verdict
);
    import wac_pkg::*;

    typedef struct packed {
        logic         ack;
        logic [31:0]  rdData;
        logic [15:0]  cfgNormal;
        logic [15:0]  cfgPf;
        logic [15:0]  cfgNsPf;
        logic         vendorStd;
        logic [15:0]  failCount;
        wac_verdict_t vd;
    } wac_state_t;

    wac_state_t state;
    wac_state_t next_state;

    logic [15:0] reportPf;
    logic [15:0] reportNsPf;
    logic [11:0] regIdx;
    logic [31:0] readWord;
    logic [31:0] curWord;
    logic [31:0] newWord;
    logic        hit;
    logic        bigNs;

    assign regIdx = wbReq.adr[13:2];
    assign reportPf = (state.cfgPf > state.cfgNormal) ? state.cfgNormal : state.cfgPf;
    assign bigNs = state.cfgNsPf > reportPf;
    assign reportNsPf = bigNs ? state.cfgNsPf : reportPf;

    // read mux; unmapped words read zero
    always_comb begin
        readWord = 32'h0000_0000;
        hit = 1'b1;
        unique case (regIdx)
            WAC_IDX_NORMAL:  readWord = {16'h0000, state.cfgNormal};
            WAC_IDX_PWRFAIL: readWord = {16'h0000, reportPf};
            WAC_IDX_VENDOR:  readWord = {31'h0000_0000, state.vendorStd};
            WAC_IDX_RSVD:    readWord = 32'h0000_0000;
            WAC_IDX_SIZECFG: readWord = {state.cfgPf, state.cfgNormal};
            WAC_IDX_NSCFG:   readWord = {15'h0000, state.vendorStd, state.cfgNsPf};
            WAC_IDX_STATUS:  readWord = {state.failCount, 12'h000, state.vd.noGuarantee,
                                         state.vd.restorePrev, state.vd.pfAtomic,
                                         state.vd.atomic};
            WAC_IDX_NSPF:    readWord = {16'h0000, reportNsPf};
            default:         hit = 1'b0;
        endcase
    end

    // byte-lane merge of write data into the addressed word
    always_comb begin
        curWord = 32'h0000_0000;
        if (regIdx == WAC_IDX_SIZECFG) begin
            curWord = {state.cfgPf, state.cfgNormal};
        end else if (regIdx == WAC_IDX_NSCFG) begin
            curWord = {15'h0000, state.vendorStd, state.cfgNsPf};
        end
        for (int i = 0; i < 4; i++) begin
            newWord[8*i +: 8] = wbReq.sel[i] ? wbReq.dat[8*i +: 8] : curWord[8*i +: 8];
        end
    end

    always_comb begin
        next_state = state;
        next_state.ack = wbReq.cyc & wbReq.stb & ~state.ack;
        next_state.vd.valid = 1'b0;
        next_state.vd.restorePrev = 1'b0;
        next_state.vd.noGuarantee = 1'b0;
        if (wbReq.cyc & wbReq.stb & ~state.ack) begin
            next_state.rdData = hit ? readWord : 32'h0000_0000;
            if (wbReq.we) begin
                if (regIdx == WAC_IDX_SIZECFG) begin
                    next_state.cfgNormal = newWord[15:0];
                    next_state.cfgPf = newWord[WAC_POS_PF_CFG +: 16];
                end else if (regIdx == WAC_IDX_NSCFG) begin
                    next_state.cfgNsPf = newWord[15:0];
                    next_state.vendorStd = newWord[WAC_POS_VENDOR_CFG];
                end
            end
        end
        if (cmd.valid & cmd.isWrite) begin
            next_state.vd.valid = 1'b1;
            // normal size says nothing about power failure, so only pfAtomic covers failures
            next_state.vd.atomic = (state.cfgNormal == WAC_ALL_ATOMIC)
                                 | (cmd.blocks <= state.cfgNormal);
            next_state.vd.pfAtomic = cmd.blocks <= reportPf;
            if (cmd.failed) begin
                next_state.vd.restorePrev = cmd.blocks <= reportPf;
                next_state.vd.noGuarantee = cmd.blocks > reportPf;
                if (state.failCount != 16'hffff) begin
                    next_state.failCount = state.failCount + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state.ack <= 1'b0;
            state.rdData <= 32'h0000_0000;
            state.cfgNormal <= WAC_RST_NORMAL;
            state.cfgPf <= WAC_RST_PF;
            state.cfgNsPf <= WAC_RST_NSPF;
            state.vendorStd <= WAC_RST_VENDOR;
            state.failCount <= 16'h0000;
            state.vd <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign wbAck = state.ack;
    assign wbDatOut = state.rdData;
    assign verdict = state.vd;
endmodule // wac_capability

// >>> logic/wac_pkg.sv
/*
 package of the write atomicity capability block: register indices, field layout,
 reset values and the carrier types.
 assumes a 32-bit classic wishbone slave; each register takes one aligned word.
*/
// Operation
// - writes no larger than the normal atomic size are flagged atomic.
// - normal atomic size of all ones makes every write command atomic.
// - normal atomic size defaults to at least 128KB in logical blocks.
// - normal atomic size gives no power failure guarantee.
// - power-fail atomic size is a zero-based count of logical blocks.
// - reported power-fail size never exceeds reported normal size.
// - writes within power-fail size are flagged atomic across power failure or error.
// - failed write within power-fail size requests a return of previous data.
// - failed larger write is flagged as giving no data guarantee.
// - larger namespace power-fail size goes to the namespace field only.
// - vendor config bit 0 set means vendor commands use standard layout.
// - vendor config bits 7:1 and the next byte are reserved.
// - normal atomic size is a zero-based count of logical blocks.
package wac_pkg;
    // register indices; byte address is four times the index
    localparam logic [11:0] WAC_IDX_NORMAL  = 12'h20e;
    localparam logic [11:0] WAC_IDX_PWRFAIL = 12'h210;
    localparam logic [11:0] WAC_IDX_VENDOR  = 12'h212;
    localparam logic [11:0] WAC_IDX_RSVD    = 12'h213;
    localparam logic [11:0] WAC_IDX_SIZECFG = 12'h214;
    localparam logic [11:0] WAC_IDX_NSCFG   = 12'h215;
    localparam logic [11:0] WAC_IDX_STATUS  = 12'h216;
    localparam logic [11:0] WAC_IDX_NSPF    = 12'h217;
    // field positions
    localparam int WAC_POS_PF_CFG     = 16;
    localparam int WAC_POS_VENDOR_CFG = 16;
    localparam int WAC_POS_FAILCNT    = 16;
    // reset values: 128KB with 512-byte blocks is 256 blocks, stored zero-based
    localparam int WAC_LBA_BYTES  = 512;
    localparam int WAC_MIN_BYTES  = 128 * 1024;
    localparam logic [15:0] WAC_RST_NORMAL = 16'((WAC_MIN_BYTES / WAC_LBA_BYTES) - 1);
    localparam logic [15:0] WAC_RST_PF     = 16'h0007;
    localparam logic [15:0] WAC_RST_NSPF   = 16'h0000;
    localparam logic        WAC_RST_VENDOR = 1'b1;
    localparam logic [15:0] WAC_ALL_ATOMIC = 16'hffff;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [13:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wac_wb_req_t;

    typedef struct packed {
        logic        valid;   // one-cycle command strobe
        logic        isWrite;
        logic        failed;  // write completed with failure
        logic [15:0] blocks;  // zero-based block count
    } wac_cmd_t;

    typedef struct packed {
        logic atomic;
        logic pfAtomic;
        logic restorePrev;
        logic noGuarantee;
        logic valid;
    } wac_verdict_t;
endpackage

// >>> verif/wac_capability_checker.sv
/*
 port assertions for the capability block.
 assumes a bind onto wac_capability.
*/
`timescale 1ns/1ps
module wac_capability_checker (
    input wire logic                  ref_clk,  // clock
    input wire logic                  rst_b,    // reset
    input wire wac_pkg::wac_wb_req_t  wbReq,    // bus request
    input wire logic                  wbAck,    // bus ack
    input wire logic [31:0]           wbDatOut, // read data
    input wire wac_pkg::wac_cmd_t     cmd,      // command
    input wire wac_pkg::wac_verdict_t verdict   // verdict
);
    import wac_pkg::*;
    wire wrCmd = cmd.valid && cmd.isWrite;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_ack_next: assert property (wbReq.cyc && wbReq.stb && !wbAck |=> wbAck)
        else $error("ack late");
    a_ack_pulse: assert property (wbAck |=> !wbAck) else $error("ack held");
    a_rsvd_zero: assert property (wbAck && !$past(wbReq.we)
        && $past(wbReq.adr[13:2]) == WAC_IDX_RSVD |-> wbDatOut == 32'h0) else $error("rsvd");
    a_vendor_bits: assert property (wbAck && !$past(wbReq.we)
        && $past(wbReq.adr[13:2]) == WAC_IDX_VENDOR |-> wbDatOut[31:1] == 31'h0)
        else $error("vendor");
    a_verdict_lat: assert property (wrCmd |=> verdict.valid) else $error("no verdict");
    a_read_quiet: assert property (!wrCmd |=> !verdict.valid) else $error("stray verdict");
    a_fail_split: assert property (wrCmd && cmd.failed |=>
        verdict.restorePrev != verdict.noGuarantee) else $error("fail verdict");
    a_restore_pf: assert property (verdict.restorePrev |-> verdict.pfAtomic)
        else $error("restore");
    a_noguar_pf: assert property (verdict.noGuarantee |-> !verdict.pfAtomic)
        else $error("noguar");
    a_zero_blocks: assert property (wrCmd && cmd.blocks == 16'h0 |=>
        verdict.atomic && verdict.pfAtomic) else $error("zero size");
    c_restore: cover property (verdict.restorePrev);
    c_noguar: cover property (verdict.noGuarantee);
    c_ack: cover property (wbAck);
endmodule // wac_capability_checker

// >>> verif/wac_host_model.sv
/*
 host command source.
 assumes the bench calls issue on ref_clk.
*/
`timescale 1ns/1ps
module wac_host_model (
    input wire logic          ref_clk, // clock
    output wac_pkg::wac_cmd_t cmd      // command
);
    import wac_pkg::*;
    initial cmd = '0;
    task automatic issue(input logic w, input logic f, input logic [15:0] b);
        @(posedge ref_clk);
        cmd <= '{1'b1, w, f, b};
        @(posedge ref_clk);
        cmd <= {1'b0, ~cmd[17:0]}; // idle fields scrambled
    endtask
endmodule // wac_host_model

// >>> verif/write_atomicity_capability_test.sv
/*
 self-checking bench for the capability block.
 assumes the checker and host model files compile first.
*/
`timescale 1ns/1ps
module write_atomicity_capability_test;
    import wac_pkg::*;
    logic         ref_clk = 1'b0;
    logic         rst_b = 1'b0;
    wac_wb_req_t  wbReq = '0;
    logic         wbAck;
    logic [31:0]  wbDatOut;
    wac_cmd_t     cmd;
    wac_verdict_t verdict;
    logic [31:0]  q;
    int           n_mismatch = 0;
    int           tests_run = 0;
    always #2 ref_clk = ~ref_clk;
    wac_capability i_wac_capability (.ref_clk(ref_clk), .rst_b(rst_b), .wbReq(wbReq),
        .wbAck(wbAck), .wbDatOut(wbDatOut), .cmd(cmd), .verdict(verdict));
    wac_host_model i_wac_host_model (.ref_clk(ref_clk), .cmd(cmd));
    task automatic wrap_up;
        $display("mismatches %0d of %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] d);
        @(posedge ref_clk);
        wbReq <= '{1'b1, 1'b1, w, {idx, 2'b00}, 4'hf, d};
        @(posedge ref_clk);
        while (wbAck !== 1'b1) @(posedge ref_clk);
        q = wbDatOut;
        wbReq <= '0;
    endtask
    task automatic rdchk(input logic [11:0] idx, input logic [31:0] e);
        bus(1'b0, idx, 32'h0);
        chk(q, e);
    endtask
    // verdict bits: atomic, pfAtomic, restorePrev, noGuarantee, valid
    task automatic cmdchk(input logic w, input logic f, input logic [15:0] b,
                          input logic [4:0] e);
        i_wac_host_model.issue(w, f, b);
        #1 chk({27'h0, verdict}, {27'h0, e});
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        rdchk(WAC_IDX_NORMAL, 32'h0000_00ff);
        bus(1'b1, WAC_IDX_NORMAL, 32'h0000_0001);
        rdchk(WAC_IDX_NORMAL, 32'h0000_00ff);
        rdchk(WAC_IDX_PWRFAIL, 32'h0000_0007);
        rdchk(WAC_IDX_VENDOR, 32'h0000_0001);
        rdchk(WAC_IDX_RSVD, 32'h0000_0000);
        rdchk(12'h100, 32'h0000_0000);
        $display("test registers done");
        cmdchk(1'b1, 1'b0, 16'h0007, 5'h19);
        cmdchk(1'b1, 1'b1, 16'h0007, 5'h1d);
        cmdchk(1'b1, 1'b1, 16'h0008, 5'h13);
        cmdchk(1'b1, 1'b0, 16'h0100, 5'h01);
        cmdchk(1'b1, 1'b0, 16'h00ff, 5'h11);
        cmdchk(1'b0, 1'b0, 16'h0000, 5'h10);
        $display("test verdicts done");
        bus(1'b1, WAC_IDX_SIZECFG, 32'h0200_ffff);
        cmdchk(1'b1, 1'b0, 16'hffff, 5'h11);
        rdchk(WAC_IDX_STATUS, 32'h0002_0001);
        bus(1'b1, WAC_IDX_SIZECFG, 32'h0020_0010);
        rdchk(WAC_IDX_PWRFAIL, 32'h0000_0010);
        bus(1'b1, WAC_IDX_NSCFG, 32'h0001_0030);
        rdchk(WAC_IDX_NSPF, 32'h0000_0030);
        rdchk(WAC_IDX_PWRFAIL, 32'h0000_0010);
        bus(1'b1, WAC_IDX_NSCFG, 32'h0000_0030);
        rdchk(WAC_IDX_VENDOR, 32'h0000_0000);
        $display("test config done");
        wrap_up;
    end
    initial begin
        repeat (2000) @(posedge ref_clk);
        n_mismatch++;
        wrap_up;
    end
endmodule // write_atomicity_capability_test
bind wac_capability wac_capability_checker i_wac_capability_checker (.ref_clk(ref_clk),
    .rst_b(rst_b), .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut), .cmd(cmd),
    .verdict(verdict));
